/* File: design/timer_defines.svh */
`ifndef TIMER_DEFINES_SVH
`define TIMER_DEFINES_SVH

// apb byte addresses, one aligned word each
`define ADDR_TMODE 8'h00
`define ADDR_TCTRL 8'h04
`define ADDR_T0_LOW 8'h08
`define ADDR_T0_HIGH 8'h0c
`define ADDR_T1_LOW 8'h10
`define ADDR_T1_HIGH 8'h14
`define ADDR_T2_CTRL 8'h18
`define ADDR_T2_MODE 8'h1c
`define ADDR_T2_LOW 8'h20
`define ADDR_T2_HIGH 8'h24
`define ADDR_CAP_LOW 8'h28
`define ADDR_CAP_HIGH 8'h2c
`define ADDR_PCTRL 8'h30

// timer mode register fields
`define TM_GATE1 7
`define TM_CT1 6
`define TM_MODE1 4
`define TM_GATE0 3
`define TM_CT0 2
`define TM_MODE0 0

// timer control register fields
`define TC_TF1 7
`define TC_TR1 6
`define TC_TF0 5
`define TC_TR0 4

// third timer control fields
`define T2C_TF2 7
`define T2C_THIRD_EXTERNAL_FLAG 6
`define T2C_RCLK 5
`define T2C_UART_A_TX_CLOCK_SELECT 4
`define T2C_TRIGGER_PIN_ENABLE 3
`define T2C_TR2 2
`define T2C_CT2 1
`define T2C_CPRL2 0

// third timer mode register and power control fields
`define T2M_DCE 0
`define PC_RX_B 5
`define PC_TX_B 4

// pin vector indices
`define PIN_C0 0
`define PIN_C1 1
`define PIN_T2IN 2
`define PIN_TRIG 3
`define PIN_G0 4
`define PIN_G1 5
`define PIN_N 6

// baud clock select indices
`define SEL_UA_RX 3
`define SEL_UA_TX 2
`define SEL_UB_RX 1
`define SEL_UB_TX 0

// clock and machine cycle timing
`define PCLK_MHZ 50
`define MC_OSC_PERIODS 12
`define MC_DIV_LAST (`MC_OSC_PERIODS - 1)

// reset and fill values
`define RST_DATA 32'h0000_0000

`endif

/* File: design/timer_pkg.sv */
package timer_pkg;

	// two-bit mode field of timers 0 and 1
	typedef enum logic [1:0] {
		MODE_13BIT,
		MODE_16BIT,
		MODE_RELOAD8,
		MODE_SPLIT
	} tmode_t;

	// whole state of the main block
	typedef struct packed {
		logic [7:0] tmod;
		logic [7:0] tcon;
		logic [7:0] t0_low_count;
		logic [7:0] t0_high_count;
		logic [7:0] t1_low_count;
		logic [7:0] t1_high_count;
		logic [7:0] third_timer_control;
		logic down_count_enable;
		logic [15:0] third_count;
		logic [15:0] capture_reload;
		logic [1:0] power_control_register_sel;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic t0_irq;
		logic t1_irq;
		logic t2_irq;
		logic t1_ovf;
		logic t2_ovf;
	} core_state_t;

	// prescaler and pin sampling state
	typedef struct packed {
		logic [3:0] div;
		logic tick;
		logic [5:0] meta;
		logic [5:0] sync;
		logic [5:0] prev;
		logic [5:0] fall;
	} tick_state_t;

	// registered serial clock pulses
	typedef struct packed {
		logic [3:0] clk;
	} route_state_t;

endpackage

/* File: design/timer_link_if.sv */
`timescale 1ns/100ps
interface timer_link_if;
	logic tick;           // machine cycle pulse
	logic [5:0] fall;     // pin falling edges, aligned to tick
	logic [5:0] level;    // synchronised pin levels
	logic t1_ovf;         // timer 1 overflow pulse
	logic t2_ovf;         // third timer overflow pulse
	logic [3:0] sel;      // third timer chosen as baud clock
	logic [3:0] baud_clk; // serial clock pulses
	modport gen (output tick, output fall, output level);
	modport core (input tick, input fall, input level, input baud_clk,
		output t1_ovf, output t2_ovf, output sel);
	modport route (input t1_ovf, input t2_ovf, input sel,
		output baud_clk);
endinterface // timer_link_if

/* File: design/tick_gen.sv */
`timescale 1ns/100ps
`include "timer_defines.svh"
module tick_gen
	import timer_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// raw pins from outside
	input wire logic [5:0] pin_raw,
	// ticks and edges to the core
	timer_link_if.gen lk
);

	tick_state_t s_ff;  // registered state
	tick_state_t nxt_s; // next state

	// prescaler, two-flop sync, edge sampling once per machine cycle
	always_comb begin
		nxt_s = s_ff;
		nxt_s.meta = pin_raw;
		nxt_s.sync = s_ff.meta;
		nxt_s.tick = 1'b0;
		nxt_s.fall = '0;
		// RQ22 machine cycle rate
		if (s_ff.div == 4'(`MC_DIV_LAST)) begin
			nxt_s.div = '0;
			nxt_s.tick = 1'b1;
			// edges seen tick to tick, so at most one per two cycles
			nxt_s.prev = s_ff.sync;
			nxt_s.fall = s_ff.prev & ~s_ff.sync;
		end else begin
			nxt_s.div = s_ff.div + 4'h1;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign lk.tick = s_ff.tick;
	assign lk.fall = s_ff.fall;
	assign lk.level = s_ff.sync;

	// RQ22 tick spacing
	AST_TICK_GAP: assert property ( // RQ22
		@(posedge pclk) disable iff (!presetn)
		s_ff.tick |=> !s_ff.tick [*8])
		else $error("machine tick came too early");

endmodule // tick_gen

/* File: design/baud_route.sv */
`timescale 1ns/100ps
`include "timer_defines.svh"
module baud_route
	import timer_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// overflow pulses in, serial clocks out
	timer_link_if.route lk
);

	route_state_t s_ff;  // registered pulses
	route_state_t nxt_s; // next pulses

	// each serial clock takes third timer or timer 1 overflow
	always_comb begin
		nxt_s = s_ff;
		// RQ15 RQ16 RQ17 clock source
		for (int i = 0; i < 4; i++) begin
			nxt_s.clk[i] = lk.sel[i] ? lk.t2_ovf : lk.t1_ovf;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign lk.baud_clk = s_ff.clk;

	// RQ15 source follows select
	AST_ROUTE_SEL: assert property ( // RQ15
		@(posedge pclk) disable iff (!presetn)
		lk.sel[`SEL_UA_RX] && lk.t2_ovf |=> s_ff.clk[`SEL_UA_RX])
		else $error("receive clock missed third timer overflow");

endmodule // baud_route

/* File: design/timer_block.sv */
`timescale 1ns/100ps
`include "timer_defines.svh"
// Function
// RQ1: timer 1 eight-bit reload from high byte
// RQ2: timer 0 same eight-bit reload
// RQ3: timer 1 mode 3 holds count
// RQ4: timer 0 split, low byte keeps controls
// RQ5: split high byte drives timer 1 flag
// RQ6: timer 1 overflow then only clocks serial
// RQ7: third timer counts ticks or pin edges
// RQ8: capture mode sixteen-bit up count, flag
// RQ9: trigger edge captures count, sets flag
// RQ10: rollover reloads from capture register
// RQ11: trigger edge forces reload, sets flag
// RQ12: trigger enable gates edges, baud excluded
// RQ13: baud clock use never sets overflow
// RQ14: baud use forces auto-reload
// RQ15: receive select picks third timer clock
// RQ16: transmit select picks third timer clock
// RQ17: second uart has own select pair
// RQ18: third timer runs only with run bit
// RQ19: flags sticky, cleared only by software
// RQ20: select bit picks capture or reload
// RQ21: down count follows trigger pin level
// RQ22: tick every twelve, edges every 24
// RQ23: run bit and gate enable counting
// RQ24: mode field picks reload or split
module timer_block
	import timer_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// count and gate pins
	input wire logic t0_count_pin,
	input wire logic t1_count_pin,
	input wire logic third_count_input,
	input wire logic trigger_pin,
	input wire logic t0_external_gate_pin,
	input wire logic t1_external_gate_pin,
	// interrupt requests
	output logic t0_irq,
	output logic t1_irq,
	output logic t2_irq,
	// serial port clocks
	output logic uart_a_rx_clk,
	output logic uart_a_tx_clk,
	output logic uart_b_rx_clk,
	output logic uart_b_tx_clk
);

	core_state_t s_ff;        // registered state
	core_state_t nxt_s;       // next state
	logic [5:0] pin_vec;      // raw pins in index order
	tmode_t mode0;            // timer 0 mode
	tmode_t mode1;            // timer 1 mode
	logic split;              // timer 0 in mode 3
	logic inc0;               // timer 0 low count step
	logic inc1;               // timer 1 count step
	logic inc0h;              // split high byte step
	logic baud;               // third timer clocks a serial port
	logic capture;            // capture mode active
	logic updown;             // down count mode active
	logic inc2;               // third timer count step
	logic trig_evt;           // accepted trigger falling edge
	logic setup;              // first access cycle
	logic wr;                 // write completing now

	timer_link_if lk();

	// pin sampling and machine tick
	tick_gen u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.pin_raw(pin_vec),
		.lk(lk)
	);

	// serial clock selection
	baud_route u_route (
		.pclk(pclk),
		.presetn(presetn),
		.lk(lk)
	);

	assign pin_vec[`PIN_C0] = t0_count_pin;
	assign pin_vec[`PIN_C1] = t1_count_pin;
	assign pin_vec[`PIN_T2IN] = third_count_input;
	assign pin_vec[`PIN_TRIG] = trigger_pin;
	assign pin_vec[`PIN_G0] = t0_external_gate_pin;
	assign pin_vec[`PIN_G1] = t1_external_gate_pin;

	// apb phases; one wait state, so pready comes from a flop
	assign setup = psel & penable & ~s_ff.pready;
	assign wr = psel & penable & s_ff.pready & pwrite;

	// RQ24 mode decode
	assign mode0 = tmode_t'(s_ff.tmod[`TM_MODE0 +: 2]);
	assign mode1 = tmode_t'(s_ff.tmod[`TM_MODE1 +: 2]);
	assign split = (mode0 == MODE_SPLIT);

	// RQ23 run and gate
	assign inc0 = s_ff.tcon[`TC_TR0]
		& (~s_ff.tmod[`TM_GATE0] | lk.level[`PIN_G0])
		& (s_ff.tmod[`TM_CT0] ? lk.fall[`PIN_C0] : lk.tick);
	assign inc1 = s_ff.tcon[`TC_TR1]
		& (~s_ff.tmod[`TM_GATE1] | lk.level[`PIN_G1])
		& (s_ff.tmod[`TM_CT1] ? lk.fall[`PIN_C1] : lk.tick);
	// RQ5 high byte times only
	assign inc0h = split & s_ff.tcon[`TC_TR1] & lk.tick;

	// RQ14 baud use overrides the select bit
	assign baud = s_ff.third_timer_control[`T2C_RCLK]
		| s_ff.third_timer_control[`T2C_UART_A_TX_CLOCK_SELECT] | (|s_ff.power_control_register_sel);
	// RQ20 capture or reload
	assign capture = s_ff.third_timer_control[`T2C_CPRL2] & ~baud;
	assign updown = ~s_ff.third_timer_control[`T2C_CPRL2] & ~baud
		& s_ff.down_count_enable;
	// RQ7 RQ18 count source and run
	assign inc2 = s_ff.third_timer_control[`T2C_TR2]
		& (s_ff.third_timer_control[`T2C_CT2] ? lk.fall[`PIN_T2IN]
		: lk.tick);
	// RQ12 trigger enable
	assign trig_evt = s_ff.third_timer_control[`T2C_TRIGGER_PIN_ENABLE]
		& lk.fall[`PIN_TRIG] & ~updown;

	assign lk.t1_ovf = s_ff.t1_ovf;
	assign lk.t2_ovf = s_ff.t2_ovf;
	assign lk.sel[`SEL_UA_RX] = s_ff.third_timer_control[`T2C_RCLK];
	assign lk.sel[`SEL_UA_TX] = s_ff.third_timer_control[`T2C_UART_A_TX_CLOCK_SELECT];
	assign lk.sel[`SEL_UB_RX] = s_ff.power_control_register_sel[1];
	assign lk.sel[`SEL_UB_TX] = s_ff.power_control_register_sel[0];

	// one step of a timer 0 or 1 pair; bit 16 flags the overflow
	function automatic logic [16:0] step01(tmode_t m, logic [7:0] hi,
		logic [7:0] lo);
		logic [16:0] r;
		r = {1'b0, hi, lo};
		case (m)
			MODE_13BIT: begin
				// low five bits prescale the high byte
				if (&lo[4:0]) begin
					r[7:0] = {lo[7:5], 5'h00};
					r[15:8] = hi + 8'h01;
					r[16] = &hi;
				end else begin
					r[4:0] = lo[4:0] + 5'h01;
				end
			end
			MODE_16BIT: begin
				r = {1'b0, hi, lo} + 17'h0_0001;
			end
			// RQ1 RQ2 reload keeps high byte
			MODE_RELOAD8: begin
				if (&lo) begin
					r = {1'b1, hi, hi};
				end else begin
					r[7:0] = lo + 8'h01;
				end
			end
			default: begin
				// split low byte: plain eight-bit wrap
				r[7:0] = lo + 8'h01;
				r[16] = &lo;
			end
		endcase
		return r;
	endfunction

	// counting, trigger events, register access
	always_comb begin
		logic [16:0] r0;
		logic [16:0] r1;
		logic set_tf0;
		logic set_tf1;
		logic set_tf2;
		logic set_exf;
		logic [31:0] rd;
		logic hit;
		r0 = step01(mode0, s_ff.t0_high_count, s_ff.t0_low_count);
		r1 = step01(mode1, s_ff.t1_high_count, s_ff.t1_low_count);
		set_tf0 = 1'b0;
		set_tf1 = 1'b0;
		set_tf2 = 1'b0;
		set_exf = 1'b0;
		rd = `RST_DATA;
		hit = 1'b1;
		nxt_s = s_ff;
		nxt_s.t1_ovf = 1'b0;
		nxt_s.t2_ovf = 1'b0;

		// RQ4 timer 0 low byte own controls
		if (inc0) begin
			nxt_s.t0_low_count = r0[7:0];
			if (!split) begin
				nxt_s.t0_high_count = r0[15:8];
			end
			set_tf0 = r0[16];
		end
		// RQ5 split high byte sets timer 1 flag
		if (inc0h) begin
			nxt_s.t0_high_count = s_ff.t0_high_count + 8'h01;
			set_tf1 = &s_ff.t0_high_count;
		end
		// RQ3 mode 3 freezes timer 1
		if (inc1 && mode1 != MODE_SPLIT) begin
			nxt_s.t1_low_count = r1[7:0];
			nxt_s.t1_high_count = r1[15:8];
			nxt_s.t1_ovf = r1[16];
			// RQ6 no timer 1 flag while split
			if (!split) begin
				set_tf1 = set_tf1 | r1[16];
			end
		end

		// third timer counting
		if (inc2) begin
			if (capture) begin
				// RQ8 free up count
				nxt_s.third_count = s_ff.third_count + 16'h0001;
				set_tf2 = &s_ff.third_count;
				nxt_s.t2_ovf = &s_ff.third_count;
			end else if (updown && !lk.level[`PIN_TRIG]) begin
				// RQ21 down count, wraps at reload value
				if (s_ff.third_count == s_ff.capture_reload) begin
					nxt_s.third_count = '1;
					set_tf2 = 1'b1;
					nxt_s.t2_ovf = 1'b1;
				end else begin
					nxt_s.third_count = s_ff.third_count - 16'h0001;
				end
			end else if (&s_ff.third_count) begin
				// RQ10 RQ14 reload on rollover
				nxt_s.third_count = s_ff.capture_reload;
				// RQ13 no flag in baud use
				set_tf2 = ~baud;
				nxt_s.t2_ovf = 1'b1;
			end else begin
				nxt_s.third_count = s_ff.third_count + 16'h0001;
			end
		end
		if (trig_evt) begin
			set_exf = 1'b1;
			if (capture) begin
				// RQ9 capture present count
				nxt_s.capture_reload = s_ff.third_count;
			end else if (!baud) begin
				// RQ11 edge forced reload
				nxt_s.third_count = s_ff.capture_reload;
			end
		end

		// read mux, unmapped address answers with an error
		case (paddr)
			`ADDR_TMODE: rd[7:0] = s_ff.tmod;
			`ADDR_TCTRL: rd[7:0] = s_ff.tcon;
			`ADDR_T0_LOW: rd[7:0] = s_ff.t0_low_count;
			`ADDR_T0_HIGH: rd[7:0] = s_ff.t0_high_count;
			`ADDR_T1_LOW: rd[7:0] = s_ff.t1_low_count;
			`ADDR_T1_HIGH: rd[7:0] = s_ff.t1_high_count;
			`ADDR_T2_CTRL: rd[7:0] = s_ff.third_timer_control;
			`ADDR_T2_MODE: rd[`T2M_DCE] = s_ff.down_count_enable;
			`ADDR_T2_LOW: rd[7:0] = s_ff.third_count[7:0];
			`ADDR_T2_HIGH: rd[7:0] = s_ff.third_count[15:8];
			`ADDR_CAP_LOW: rd[7:0] = s_ff.capture_reload[7:0];
			`ADDR_CAP_HIGH: rd[7:0] = s_ff.capture_reload[15:8];
			`ADDR_PCTRL: begin
				rd[`PC_RX_B] = s_ff.power_control_register_sel[1];
				rd[`PC_TX_B] = s_ff.power_control_register_sel[0];
			end
			default: hit = 1'b0;
		endcase

		// software writes win over counting
		if (wr) begin
			case (paddr)
				`ADDR_TMODE: nxt_s.tmod = pwdata[7:0];
				`ADDR_TCTRL: nxt_s.tcon = pwdata[7:0];
				`ADDR_T0_LOW: nxt_s.t0_low_count = pwdata[7:0];
				`ADDR_T0_HIGH: nxt_s.t0_high_count = pwdata[7:0];
				`ADDR_T1_LOW: nxt_s.t1_low_count = pwdata[7:0];
				`ADDR_T1_HIGH: nxt_s.t1_high_count = pwdata[7:0];
				`ADDR_T2_CTRL: nxt_s.third_timer_control = pwdata[7:0];
				`ADDR_T2_MODE: nxt_s.down_count_enable = pwdata[`T2M_DCE];
				`ADDR_T2_LOW: nxt_s.third_count[7:0] = pwdata[7:0];
				`ADDR_T2_HIGH: nxt_s.third_count[15:8] = pwdata[7:0];
				`ADDR_CAP_LOW: nxt_s.capture_reload[7:0] = pwdata[7:0];
				`ADDR_CAP_HIGH: nxt_s.capture_reload[15:8] = pwdata[7:0];
				`ADDR_PCTRL: begin
					nxt_s.power_control_register_sel = {pwdata[`PC_RX_B], pwdata[`PC_TX_B]};
				end
				default: nxt_s.tmod = s_ff.tmod;
			endcase
		end

		// RQ19 hardware sets beat software clears
		nxt_s.tcon[`TC_TF0] = nxt_s.tcon[`TC_TF0] | set_tf0;
		nxt_s.tcon[`TC_TF1] = nxt_s.tcon[`TC_TF1] | set_tf1;
		nxt_s.third_timer_control[`T2C_TF2] =
			nxt_s.third_timer_control[`T2C_TF2] | set_tf2;
		nxt_s.third_timer_control[`T2C_THIRD_EXTERNAL_FLAG] =
			nxt_s.third_timer_control[`T2C_THIRD_EXTERNAL_FLAG] | set_exf;

		// interrupt request levels follow the flags
		nxt_s.t0_irq = nxt_s.tcon[`TC_TF0];
		nxt_s.t1_irq = nxt_s.tcon[`TC_TF1];
		nxt_s.t2_irq = nxt_s.third_timer_control[`T2C_TF2]
			| nxt_s.third_timer_control[`T2C_THIRD_EXTERNAL_FLAG];

		// answer in the second access cycle
		nxt_s.pready = setup;
		nxt_s.pslverr = setup & ~hit;
		if (setup) begin
			nxt_s.prdata = rd;
		end
	end

	// state register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_ff <= '0;
		end else begin
			s_ff <= nxt_s;
		end
	end

	assign prdata = s_ff.prdata;
	assign pready = s_ff.pready;
	assign pslverr = s_ff.pslverr;
	assign t0_irq = s_ff.t0_irq;
	assign t1_irq = s_ff.t1_irq;
	assign t2_irq = s_ff.t2_irq;
	assign uart_a_rx_clk = lk.baud_clk[`SEL_UA_RX];
	assign uart_a_tx_clk = lk.baud_clk[`SEL_UA_TX];
	assign uart_b_rx_clk = lk.baud_clk[`SEL_UB_RX];
	assign uart_b_tx_clk = lk.baud_clk[`SEL_UB_TX];

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// wrap conditions, one cycle each
	sequence s_t0_wrap8;
		mode0 == MODE_RELOAD8 && inc0 && (&s_ff.t0_low_count) && !wr;
	endsequence
	sequence s_t1_wrap8;
		mode1 == MODE_RELOAD8 && inc1 && (&s_ff.t1_low_count) && !wr;
	endsequence
	sequence s_t2_roll;
		!capture && !updown && inc2 && (&s_ff.third_count)
			&& !trig_evt && !wr;
	endsequence

	// RQ2 timer 0 reload
	AST_T0_RELOAD: assert property ( // RQ2
		s_t0_wrap8 |=> s_ff.t0_low_count == $past(s_ff.t0_high_count)
			&& s_ff.tcon[`TC_TF0] && t0_irq)
		else $error("timer 0 reload wrong");
	// RQ1 timer 1 reload
	AST_T1_RELOAD: assert property ( // RQ1
		s_t1_wrap8 |=> s_ff.t1_low_count == $past(s_ff.t1_high_count)
			&& $stable(s_ff.t1_high_count) && s_ff.t1_ovf)
		else $error("timer 1 reload wrong");
	// RQ3 timer 1 hold
	AST_T1_HOLD: assert property ( // RQ3
		mode1 == MODE_SPLIT && !wr |=> $stable(s_ff.t1_low_count)
			&& $stable(s_ff.t1_high_count))
		else $error("timer 1 moved in mode 3");
	// RQ5 split high byte flag
	AST_T0H_FLAG: assert property ( // RQ5
		inc0h && (&s_ff.t0_high_count) && !wr |=> s_ff.tcon[`TC_TF1])
		else $error("split high byte did not set timer 1 flag");
	// RQ9 capture on trigger
	AST_T2_CAPTURE: assert property ( // RQ9
		capture && trig_evt && !wr |=> s_ff.capture_reload ==
			$past(s_ff.third_count)
			&& s_ff.third_timer_control[`T2C_THIRD_EXTERNAL_FLAG] ##1 t2_irq)
		else $error("capture missed");
	// RQ10 reload on rollover
	AST_T2_RELOAD: assert property ( // RQ10
		s_t2_roll |=> s_ff.third_count == $past(s_ff.capture_reload)
			&& s_ff.t2_ovf)
		else $error("third timer reload wrong");
	// RQ13 no flag in baud use
	AST_T2_BAUD: assert property ( // RQ13
		baud && !s_ff.third_timer_control[`T2C_TF2] && !wr
			|=> !s_ff.third_timer_control[`T2C_TF2])
		else $error("overflow flag set while clocking serial port");
	// RQ18 stopped timer
	AST_T2_STOP: assert property ( // RQ18
		!s_ff.third_timer_control[`T2C_TR2] && !trig_evt && !wr
			|=> $stable(s_ff.third_count))
		else $error("third timer counted while stopped");
	// RQ19 flag stays until software
	AST_EXF_KEEP: assert property ( // RQ19
		s_ff.third_timer_control[`T2C_THIRD_EXTERNAL_FLAG] && !wr
			|=> s_ff.third_timer_control[`T2C_THIRD_EXTERNAL_FLAG])
		else $error("external flag cleared by hardware");
	// bus answer timing
	AST_APB_READY: assert property (
		setup |=> pready ##1 !pready)
		else $error("apb answer not one wait state");

endmodule // timer_block

/* File: tb/pin_side.sv */
`timescale 1ns/100ps
module pin_side (
	// clock
	input wire logic pclk,
	// drop requests, one per pin
	input wire logic [5:0] drop,
	// pins towards the block
	output logic [5:0] pins,
	// serial clocks in, pulse counts out
	input wire logic [3:0] baud_clk,
	output logic [31:0] seen
);
	// start released, so the pins idle high from time zero
	int low_left [6] = '{default: 0}; // cycles still held low
	initial seen = 32'h0000_0000;
	// low long enough
	// held low 30 cycles so a 24-cycle sampler sees it
	always @(posedge pclk) begin
		for (int i = 0; i < 6; i++) begin
			if (drop[i]) begin
				low_left[i] <= 30;
			end else if (low_left[i] > 0) begin
				low_left[i] <= low_left[i] - 1;
			end
		end
	end
	// pins idle high, as pulled up lines
	always_comb begin
		for (int i = 0; i < 6; i++) begin
			pins[i] = (low_left[i] == 0);
		end
	end
	// one byte counter per serial clock line
	always @(posedge pclk) begin
		for (int i = 0; i < 4; i++) begin
			if (baud_clk[i] === 1'b1) begin
				seen[i*8 +: 8] <= seen[i*8 +: 8] + 8'h01;
			end
		end
	end
endmodule // pin_side

/* File: tb/tb.sv */
`timescale 1ns/100ps
`include "timer_defines.svh"
module tb;
	logic pclk, presetn, psel, penable, pwrite, perr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, seen, q0;
	logic pready, pslverr, t0_irq, t1_irq, t2_irq;
	logic [5:0] drop, pins;
	logic [3:0] bclk; // a rx, a tx, b rx, b tx
	logic [2:0] irq_vec; // t2, t1, t0 request levels
	assign irq_vec = {t2_irq, t1_irq, t0_irq};
	int miscompares = 0;
	int tests_run = 0;
	timer_block i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .t0_count_pin(pins[0]),
		.t1_count_pin(pins[1]), .third_count_input(pins[2]),
		.trigger_pin(pins[3]), .t0_external_gate_pin(pins[4]),
		.t1_external_gate_pin(pins[5]), .t0_irq(t0_irq),
		.t1_irq(t1_irq), .t2_irq(t2_irq), .uart_a_rx_clk(bclk[3]),
		.uart_a_tx_clk(bclk[2]), .uart_b_rx_clk(bclk[1]),
		.uart_b_tx_clk(bclk[0]));
	pin_side i_far (.pclk(pclk), .drop(drop), .pins(pins),
		.baud_clk(bclk), .seen(seen));
	// verdict and end of run
	task automatic stop_test();
		$display("comparisons %0d mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		tests_run++;
		if (s !== e) begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	// one apb transfer, bounded wait on pready, idle cycle after
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (n >= 50) begin
			miscompares++;
			stop_test();
		end
		q = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic [31:0] q;
		apb(1'b1, a, {24'h00_0000, d}, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		apb(1'b0, a, 32'h0000_0000, q);
		chk(q, e);
	endtask
	// bounded wait for one interrupt line
	task automatic wait_irq(input int i);
		int n;
		n = 0;
		while (irq_vec[i] !== 1'b1 && n < 3000) begin
			@(posedge pclk);
			n++;
		end
		if (n >= 3000) begin
			miscompares++;
			stop_test();
		end
	endtask
	// reset values, unmapped place refused
	task automatic s_reset();
		for (int a = 0; a <= 8'h30; a += 4) begin
			rd(a[7:0], 32'h0000_0000);
		end
		rd(8'h40, 32'h0000_0000);
		chk({31'h0, perr}, 32'h0000_0001);
	endtask
	// timer 1 eight-bit reload, then mode 3 hold
	task automatic s_t1();
		logic [31:0] q1;
		wr(`ADDR_T1_HIGH, 8'hfe);
		wr(`ADDR_T1_LOW, 8'hfe);
		wr(`ADDR_TMODE, 8'h20);
		wr(`ADDR_TCTRL, 8'h40);
		wait_irq(1);
		rd(`ADDR_T1_LOW, 32'h0000_00fe);
		rd(`ADDR_T1_HIGH, 32'h0000_00fe);
		chk({31'h0, seen[23:16] != 8'h00}, 32'h0000_0001);
		wr(`ADDR_TMODE, 8'h30);
		apb(1'b0, `ADDR_T1_LOW, 32'h0000_0000, q0);
		repeat (40) @(posedge pclk);
		apb(1'b0, `ADDR_T1_LOW, 32'h0000_0000, q1);
		chk(q1, q0);
	endtask
	// timer 0 split, high byte drives timer 1 flag
	task automatic s_split();
		wr(`ADDR_TCTRL, 8'h00);
		wr(`ADDR_TMODE, 8'h03);
		wr(`ADDR_T0_HIGH, 8'hfe);
		wr(`ADDR_TCTRL, 8'h40);
		wait_irq(1);
		rd(`ADDR_TCTRL, 32'h0000_00c0);
		rd(`ADDR_T0_LOW, 32'h0000_0000);
		chk({31'h0, t0_irq}, 32'h0000_0000);
		wr(`ADDR_TCTRL, 8'h00);
		wr(`ADDR_TMODE, 8'h00);
	endtask
	// third timer reload, sticky flag, software clear
	task automatic s_t2_reload();
		wr(`ADDR_CAP_LOW, 8'hf0);
		wr(`ADDR_CAP_HIGH, 8'hff);
		wr(`ADDR_T2_LOW, 8'hfe);
		wr(`ADDR_T2_HIGH, 8'hff);
		wr(`ADDR_T2_CTRL, 8'h04);
		wait_irq(2);
		rd(`ADDR_T2_LOW, 32'h0000_00f0);
		rd(`ADDR_T2_HIGH, 32'h0000_00ff);
		repeat (100) @(posedge pclk);
		rd(`ADDR_T2_CTRL, 32'h0000_0084);
		wr(`ADDR_T2_CTRL, 8'h00);
		repeat (2) @(posedge pclk);
		chk({31'h0, t2_irq}, 32'h0000_0000);
	endtask
	// capture on trigger edge, ignored with enable clear
	task automatic s_capture();
		wr(`ADDR_T2_HIGH, 8'h12);
		wr(`ADDR_T2_LOW, 8'h00);
		wr(`ADDR_T2_CTRL, 8'h0d);
		drop <= 6'b00_1000;
		@(posedge pclk);
		drop <= 6'b00_0000;
		wait_irq(2);
		rd(`ADDR_CAP_HIGH, 32'h0000_0012);
		rd(`ADDR_T2_CTRL, 32'h0000_004d);
		wr(`ADDR_T2_CTRL, 8'h05);
		drop <= 6'b00_1000;
		@(posedge pclk);
		drop <= 6'b00_0000;
		repeat (80) @(posedge pclk);
		rd(`ADDR_T2_CTRL, 32'h0000_0005);
		wr(`ADDR_T2_CTRL, 8'h00);
	endtask
	// counter select: pin edges only
	task automatic s_edges();
		wr(`ADDR_T2_HIGH, 8'h00);
		wr(`ADDR_T2_LOW, 8'h00);
		wr(`ADDR_T2_CTRL, 8'h06);
		for (int i = 0; i < 3; i++) begin
			drop <= 6'b00_0100;
			@(posedge pclk);
			drop <= 6'b00_0000;
			repeat (80) @(posedge pclk);
		end
		rd(`ADDR_T2_LOW, 32'h0000_0003);
		wr(`ADDR_T2_CTRL, 8'h00);
	endtask
	// baud use: no overflow flag, clocks routed
	task automatic s_baud();
		logic [31:0] s0;
		wr(`ADDR_CAP_LOW, 8'h00);
		wr(`ADDR_CAP_HIGH, 8'h56);
		wr(`ADDR_T2_LOW, 8'hfe);
		wr(`ADDR_T2_HIGH, 8'hff);
		wr(`ADDR_PCTRL, 8'h20);
		s0 = seen;
		wr(`ADDR_T2_CTRL, 8'h25);
		repeat (500) @(posedge pclk);
		rd(`ADDR_T2_CTRL, 32'h0000_0025);
		rd(`ADDR_T2_HIGH, 32'h0000_0056);
		chk({31'h0, seen[31:24] != s0[31:24]}, 32'h0000_0001);
		chk({31'h0, seen[15:8] != s0[15:8]}, 32'h0000_0001);
		chk({24'h0, seen[23:16]}, {24'h0, s0[23:16]});
	endtask
	// down count while trigger low, trigger edge ignored
	task automatic s_updown();
		wr(`ADDR_T2_CTRL, 8'h00);
		wr(`ADDR_PCTRL, 8'h00);
		wr(`ADDR_CAP_HIGH, 8'h00);
		wr(`ADDR_CAP_LOW, 8'h00);
		wr(`ADDR_T2_HIGH, 8'h00);
		wr(`ADDR_T2_LOW, 8'h02);
		wr(`ADDR_T2_MODE, 8'h01);
		wr(`ADDR_T2_CTRL, 8'h0c);
		// trigger held low for the whole count down
		drop <= 6'b00_1000;
		wait_irq(2);
		rd(`ADDR_T2_HIGH, 32'h0000_00ff);
		rd(`ADDR_T2_CTRL, 32'h0000_008c);
		drop <= 6'b00_0000;
		wr(`ADDR_T2_CTRL, 8'h00);
		wr(`ADDR_T2_MODE, 8'h00);
	endtask
	// free-running clock, 20 ns period
	initial begin
		pclk = 1'b0;
		forever #10 pclk = ~pclk;
	end
	// reset then scenarios in turn
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
		drop = 6'b00_0000;
		perr = 1'b0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		s_reset();
		s_t1();
		s_split();
		s_t2_reload();
		s_capture();
		s_edges();
		s_baud();
		s_updown();
		stop_test();
	end
endmodule // tb
